// File: hw/dcc_cfg.svh
// register addresses, field positions and reset values of the comparator bank
`ifndef DCC_CFG_SVH
`define DCC_CFG_SVH
`define DCC_ADDR_CMP_B_CTRL 8'h9A
`define DCC_ADDR_CMP_A_CTRL 8'h9B
`define DCC_ADDR_CMP_A_MODE 8'h9D
`define DCC_CTRL_PAGE 8'h00
`define DCC_BIT_ENABLE 7
`define DCC_BIT_OUT 6
`define DCC_BIT_RISE 5
`define DCC_BIT_FALL 4
`define DCC_BIT_HYP_HI 3
`define DCC_BIT_HYP_LO 2
`define DCC_BIT_HYN_HI 1
`define DCC_BIT_HYN_LO 0
`define DCC_BIT_MODE_RSVD 7
`define DCC_BIT_RISE_IE 5
`define DCC_BIT_FALL_IE 4
`define DCC_BIT_RESP_HI 1
`define DCC_BIT_RESP_LO 0
`define DCC_RST_HYST 2'h0
`define DCC_RST_RESP 2'h2
`define DCC_MODE_RSVD_READ 1'h1
`endif

// File: hw/dcc_pkg.sv
// types shared by the comparator register bank
package dcc_pkg;
   typedef enum logic [1:0] {
      dcc_resp_fastest = 2'b00,
      dcc_resp_mid_fast = 2'b01,
      dcc_resp_mid_slow = 2'b10,
      dcc_resp_slowest = 2'b11
   } dcc_resp_type;
   typedef enum logic [1:0] {
      dcc_hyst_none = 2'b00,
      dcc_hyst_5mv = 2'b01,
      dcc_hyst_10mv = 2'b10,
      dcc_hyst_20mv = 2'b11
   } dcc_hyst_type;
endpackage

// File: hw/dcc_channel.sv
// one comparator channel: gating, synchroniser, edge flags, control fields
`timescale 1ns/1ps
`include "dcc_cfg.svh"
module dcc_channel
   import dcc_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // register write path
   input wire logic wr_ctrl,
   input wire logic [7:0] wr_data,
   // analog side
   input wire logic raw_out,
   // state
   output logic enable,
   output logic out_state,
   output logic rise_flag,
   output logic fall_flag,
   output dcc_hyst_type pos_hyst,
   output dcc_hyst_type neg_hyst
);
   logic sync_a;
   logic prev_out;
   logic rise_hit;
   logic fall_hit;
   logic gated_raw;

   // a disabled comparator reads as logic 0
   assign gated_raw = raw_out & enable;

   // enable bit, cleared at reset; 0 drops the channel to shutdown
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         enable <= 1'b0;
      end else if (wr_ctrl) begin
         enable <= wr_data[`DCC_BIT_ENABLE];
      end
   end

   // two-stage synchroniser; first stage feeds only the second
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sync_a <= 1'b0;
         out_state <= 1'b0;
         prev_out <= 1'b0;
      end else begin
         sync_a <= gated_raw;
         out_state <= sync_a & enable;
         prev_out <= out_state;
      end
   end

   // edge detection on the synchronised level, one cycle apart;
   // gated by enable so a shutdown with the output high leaves no flag
   assign rise_hit = out_state & ~prev_out & enable;
   assign fall_hit = ~out_state & prev_out & enable;

   // sticky flags: a detected edge wins over a software clear
   // spurious edges after power-up or mode change are not filtered
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rise_flag <= 1'b0;
         fall_flag <= 1'b0;
      end else begin
         if (rise_hit) begin
            rise_flag <= 1'b1;
         end else if (wr_ctrl) begin
            rise_flag <= wr_data[`DCC_BIT_RISE];
         end
         if (fall_hit) begin
            fall_flag <= 1'b1;
         end else if (wr_ctrl) begin
            fall_flag <= wr_data[`DCC_BIT_FALL];
         end
      end
   end

   // hysteresis selections
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pos_hyst <= dcc_hyst_type'(`DCC_RST_HYST);
         neg_hyst <= dcc_hyst_type'(`DCC_RST_HYST);
      end else if (wr_ctrl) begin
         pos_hyst <= dcc_hyst_type'(
            wr_data[`DCC_BIT_HYP_HI:`DCC_BIT_HYP_LO]);
         neg_hyst <= dcc_hyst_type'(
            wr_data[`DCC_BIT_HYN_HI:`DCC_BIT_HYN_LO]);
      end
   end
endmodule // dcc_channel

// File: hw/dcc_top.sv
// dual comparator control and mode registers on the special-function bus
//
// Summary of operation
// - A comparator does nothing until its enable bit is written to 1.
// - Writing enable 0 turns the comparator off into low power state.
// - Edge flags may set spuriously at power-up or after mode changes.
// - Control bit 7 is read/write enable, reset value 0.
// - Control bit 6 reads synchronised comparator output state.
// - Control bit 5 sets on rising edge, stays until software writes 0.
// - Control bit 4 sets on falling edge, stays until software writes 0.
// - Control bits 3:2 select positive hysteresis: none, 5, 10, 20 mV.
// - Control bits 1:0 select negative hysteresis, same four codes.
// - Mode bits 1:0 select response time, 00 fastest, 11 slowest.
// - Mode bit 5 enables rising-edge interrupt, resets to 0.
// - Mode bit 4 enables falling-edge interrupt, resets to 0.
// - Mode bit 7 reads 1; software always writes 1.
// - Mode bits 6 and 3:2 read 0 and ignore writes.
// - Mode at 0x9D on all pages; controls at 0x9B/0x9A on page 0.
// - Second comparator has an identical control register.
// - Disabled comparator output is forced 0, then synchronised.
// - Edge flags set regardless of interrupt enables.
// - Interrupt only when flag, edge enable, source and global enables.
`timescale 1ns/1ps
`include "dcc_cfg.svh"
module dcc_top
   import dcc_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // special-function register bus
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_page,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   output logic sfr_hit,
   // interrupt controller
   input wire logic cmp_irq_source_enable,
   input wire logic global_irq_enable,
   output logic cmp_irq_request,
   // analog comparator a
   input wire logic cmp_a_raw,
   output logic cmp_a_power_on,
   output dcc_hyst_type cmp_a_pos_hysteresis,
   output dcc_hyst_type cmp_a_neg_hysteresis,
   output dcc_resp_type cmp_a_response_mode,
   // analog comparator b
   input wire logic cmp_b_raw,
   output logic cmp_b_power_on,
   output dcc_hyst_type cmp_b_pos_hysteresis,
   output dcc_hyst_type cmp_b_neg_hysteresis
);
   // address decode shared by read and write paths
   function automatic logic [2:0] decode(input logic [7:0] addr,
                                         input logic [7:0] page);
      logic [2:0] sel;
      sel = 3'h0;
      if (addr == `DCC_ADDR_CMP_A_MODE) begin
         sel[2] = 1'b1;
      end
      if (page == `DCC_CTRL_PAGE) begin
         sel[0] = (addr == `DCC_ADDR_CMP_A_CTRL);
         sel[1] = (addr == `DCC_ADDR_CMP_B_CTRL);
      end
      return sel;
   endfunction

   logic [2:0] sel;
   logic [1:0] ch_enable;
   logic [1:0] ch_out;
   logic [1:0] ch_rise;
   logic [1:0] ch_fall;
   logic [1:0] ch_raw;
   logic [1:0] ch_wr;
   dcc_hyst_type ch_pos [2];
   dcc_hyst_type ch_neg [2];
   logic rise_irq_enable;
   logic fall_irq_enable;
   dcc_resp_type resp_mode;
   logic [7:0] next_rdata;
   logic [7:0] mode_word;
   logic next_irq;

   assign sel = decode(sfr_addr, sfr_page);
   assign ch_raw = {cmp_b_raw, cmp_a_raw};
   assign ch_wr = {sfr_wr & sel[1], sfr_wr & sel[0]};

   // both channels built from one module so their layouts cannot drift
   for (genvar i = 0; i < 2; i++) begin : g_ch
      dcc_channel u_ch (
         .sys_clk(sys_clk),
         .rst(rst),
         .wr_ctrl(ch_wr[i]),
         .wr_data(sfr_wdata),
         .raw_out(ch_raw[i]),
         .enable(ch_enable[i]),
         .out_state(ch_out[i]),
         .rise_flag(ch_rise[i]),
         .fall_flag(ch_fall[i]),
         .pos_hyst(ch_pos[i]),
         .neg_hyst(ch_neg[i])
      );
   end

   // mode register fields; reserved and unused bits have no storage
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rise_irq_enable <= 1'b0;
         fall_irq_enable <= 1'b0;
         resp_mode <= dcc_resp_type'(`DCC_RST_RESP);
      end else if (sfr_wr && sel[2]) begin
         rise_irq_enable <= sfr_wdata[`DCC_BIT_RISE_IE];
         fall_irq_enable <= sfr_wdata[`DCC_BIT_FALL_IE];
         resp_mode <= dcc_resp_type'(
            sfr_wdata[`DCC_BIT_RESP_HI:`DCC_BIT_RESP_LO]);
      end
   end

   // mode readback: bit 7 fixed high, bits 6 and 3:2 fixed low
   always_comb begin
      mode_word = 8'h00;
      mode_word[`DCC_BIT_MODE_RSVD] = `DCC_MODE_RSVD_READ;
      mode_word[`DCC_BIT_RISE_IE] = rise_irq_enable;
      mode_word[`DCC_BIT_FALL_IE] = fall_irq_enable;
      mode_word[`DCC_BIT_RESP_HI:`DCC_BIT_RESP_LO] = resp_mode;
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      next_rdata = 8'h00;
      if (sel[2]) begin
         next_rdata = mode_word;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (sel[i]) begin
               // output bit masked so a read right after shutdown shows 0
               next_rdata = {ch_enable[i], ch_out[i] & ch_enable[i],
                             ch_rise[i], ch_fall[i], ch_pos[i],
                             ch_neg[i]};
            end
         end
      end
   end

   // registered read data, valid the cycle after sfr_rd
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sfr_rdata <= 8'h00;
         sfr_hit <= 1'b0;
      end else begin
         sfr_rdata <= sfr_rd ? next_rdata : 8'h00;
         sfr_hit <= (sfr_rd | sfr_wr) & (|sel);
      end
   end

   // only comparator a has edge enables in this bank
   assign next_irq = ((ch_rise[0] & rise_irq_enable) |
                      (ch_fall[0] & fall_irq_enable)) &
                     cmp_irq_source_enable & global_irq_enable;

   // interrupt request registered so it comes from a flop
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cmp_irq_request <= 1'b0;
      end else begin
         cmp_irq_request <= next_irq;
      end
   end

   // analog controls, registered copies of the fields
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cmp_a_power_on <= 1'b0;
         cmp_b_power_on <= 1'b0;
         cmp_a_pos_hysteresis <= dcc_hyst_none;
         cmp_a_neg_hysteresis <= dcc_hyst_none;
         cmp_b_pos_hysteresis <= dcc_hyst_none;
         cmp_b_neg_hysteresis <= dcc_hyst_none;
         cmp_a_response_mode <= dcc_resp_type'(`DCC_RST_RESP);
      end else begin
         cmp_a_power_on <= ch_enable[0];
         cmp_b_power_on <= ch_enable[1];
         cmp_a_pos_hysteresis <= ch_pos[0];
         cmp_a_neg_hysteresis <= ch_neg[0];
         cmp_b_pos_hysteresis <= ch_pos[1];
         cmp_b_neg_hysteresis <= ch_neg[1];
         cmp_a_response_mode <= resp_mode;
      end
   end
endmodule // dcc_top

// File: verif/dcc_props.sv
// concurrent checks on the comparator register bank ports
`timescale 1ns/1ps
module dcc_props
   import dcc_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // register bus
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_page,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic sfr_hit,
   // interrupt and analog side
   input wire logic cmp_irq_source_enable,
   input wire logic global_irq_enable,
   input wire logic cmp_irq_request,
   input wire logic cmp_a_power_on,
   input wire dcc_resp_type cmp_a_response_mode,
   input wire dcc_hyst_type cmp_b_neg_hysteresis
);
   logic mode_sel;
   logic ctl_a;
   logic ctl_b;
   // decode seen from outside; controls only answer on page zero
   assign mode_sel = sfr_addr == 8'h9D;
   assign ctl_a = sfr_addr == 8'h9B && sfr_page == 8'h00;
   assign ctl_b = sfr_addr == 8'h9A && sfr_page == 8'h00;
   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_rd_unmapped: assert property (
      sfr_rd && !(mode_sel || ctl_a || ctl_b)
      |=> sfr_rdata == 8'h00 && !sfr_hit) else $error("unmapped read");
   a_hit_mapped: assert property (
      (sfr_rd || sfr_wr) && (mode_sel || ctl_a || ctl_b)
      |=> sfr_hit) else $error("mapped access missed");
   a_rdata_idle: assert property (!sfr_rd |=> sfr_rdata == 8'h00)
      else $error("read data without read");
   a_mode_fixed_bits: assert property (
      sfr_rd && mode_sel |=> sfr_rdata[7]
      && sfr_rdata[6] == 1'b0 && sfr_rdata[3:2] == 2'h0)
      else $error("mode fixed bits wrong");
   // a second write in between would move the expected value
   a_resp_follows: assert property (
      sfr_wr && mode_sel ##1 !(sfr_wr && mode_sel)
      |=> cmp_a_response_mode == $past(sfr_wdata[1:0], 2))
      else $error("response mode not applied");
   a_power_follows: assert property (
      sfr_wr && ctl_a ##1 !(sfr_wr && ctl_a)
      |=> cmp_a_power_on == $past(sfr_wdata[7], 2))
      else $error("power not following enable");
   a_hyst_b_follows: assert property (
      sfr_wr && ctl_b ##1 !(sfr_wr && ctl_b)
      |=> cmp_b_neg_hysteresis == $past(sfr_wdata[1:0], 2))
      else $error("hysteresis b not applied");
   a_irq_gated: assert property (
      cmp_irq_request |-> $past(cmp_irq_source_enable && global_irq_enable))
      else $error("irq without enables");
   a_off_out_low: assert property (
      sfr_rd && ctl_a ##1 !cmp_a_power_on |-> sfr_rdata[6] == 1'b0)
      else $error("output seen while off");
endmodule // dcc_props
bind dcc_top dcc_props u_props (.sys_clk, .rst, .sfr_addr, .sfr_page,
   .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .sfr_hit, .cmp_irq_source_enable,
   .global_irq_enable, .cmp_irq_request, .cmp_a_power_on,
   .cmp_a_response_mode, .cmp_b_neg_hysteresis);

// File: verif/tb_top.sv
// self-checking bench for the comparator register bank
`timescale 1ns/1ps
module tb_top;
   import dcc_pkg::*;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] sfr_addr = 8'h00;
   logic [7:0] sfr_page = 8'h00;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic [7:0] sfr_rdata;
   logic sfr_hit;
   logic src_en = 1'b0;
   logic glb_en = 1'b0;
   logic irq;
   logic [1:0] raw = 2'h0;
   logic [1:0] pwr;
   dcc_hyst_type hyp_a, hyn_a, hyp_b, hyn_b;
   dcc_resp_type resp;
   int n_fail = 0;
   int comparisons = 0;
   logic [7:0] d;
   logic [7:0] p;
   logic [7:0] a;
   dcc_top dut (.sys_clk, .rst, .sfr_addr, .sfr_page, .sfr_wr, .sfr_rd,
      .sfr_wdata, .sfr_rdata, .sfr_hit, .cmp_irq_source_enable(src_en),
      .global_irq_enable(glb_en), .cmp_irq_request(irq), .cmp_a_raw(raw[0]),
      .cmp_a_power_on(pwr[0]), .cmp_a_pos_hysteresis(hyp_a),
      .cmp_a_neg_hysteresis(hyn_a), .cmp_a_response_mode(resp),
      .cmp_b_raw(raw[1]), .cmp_b_power_on(pwr[1]),
      .cmp_b_pos_hysteresis(hyp_b), .cmp_b_neg_hysteresis(hyn_b));
   initial forever #10 sys_clk = ~sys_clk;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // expected control word, assembled field by field
   function automatic logic [7:0] ctrl_exp(input logic en, out, rise, fall,
                                           input logic [3:0] hyst);
      return {en, out, rise, fall, hyst};
   endfunction
   // expected mode read: bit 7 high, bits 6 and 3:2 low, rest as written
   function automatic logic [7:0] mode_exp(input logic [7:0] w);
      return {1'h1, 1'h0, w[5:4], 2'h0, w[1:0]};
   endfunction
   // one-cycle strobes; each starts a fresh edge so no signal gets two
   // assignments in one time step
   task automatic wr(input logic [7:0] ad, pg, v);
      @(posedge sys_clk);
      sfr_addr <= ad;
      sfr_page <= pg;
      sfr_wdata <= v;
      sfr_wr <= 1'b1;
      @(posedge sys_clk);
      sfr_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] ad, pg, exp);
      @(posedge sys_clk);
      sfr_addr <= ad;
      sfr_page <= pg;
      sfr_rd <= 1'b1;
      @(posedge sys_clk);
      sfr_rd <= 1'b0;
      // read data stands until the next edge; look at it mid-cycle
      @(negedge sys_clk);
      chk(sfr_rdata, exp);
   endtask
   task automatic give_verdict;
      if (n_fail == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      void'($urandom(32'hd11ec131));
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      // reset values
      rd(8'h9B, 8'h00, 8'h00);
      rd(8'h9A, 8'h00, 8'h00);
      rd(8'h9D, 8'h00, 8'h82);
      chk({6'h0, resp}, 8'h02);
      // mode register on random pages, every response code
      for (int i = 0; i < 4; i++) begin
         d = {1'h1, 5'($urandom), 2'(i)};
         p = 8'($urandom);
         wr(8'h9D, p, d);
         rd(8'h9D, ~p, mode_exp(d));
         chk({6'h0, resp}, {6'h0, d[1:0]});
      end
      // control register 0x9B refuses other pages; 0x9C is not ours
      wr(8'h9B, 8'h01, 8'h8F);
      rd(8'h9B, 8'h01, 8'h00);
      rd(8'h9B, 8'h00, 8'h00);
      rd(8'h9C, 8'h00, 8'h00);
      // every hysteresis code on both channels
      for (int i = 0; i < 32; i++) begin
         a = i[0] ? 8'h9A : 8'h9B;
         wr(a, 8'h00, {4'h0, i[4:1]});
         rd(a, 8'h00, ctrl_exp(1'h0, 1'h0, 1'h0, 1'h0, i[4:1]));
         p = {4'h0, i[0] ? {hyp_b, hyn_b} : {hyp_a, hyn_a}};
         chk(p, {4'h0, i[4:1]});
      end
      // edges, flags, interrupt and shutdown per channel
      for (int c = 0; c < 2; c++) begin
         a = c ? 8'h9A : 8'h9B;
         @(posedge sys_clk);
         raw[c] <= 1'h1;
         repeat (6) @(posedge sys_clk);
         // still off: no output, no flags; last hysteresis code 0xF stays
         rd(a, 8'h00, 8'h0F);
         @(posedge sys_clk);
         raw[c] <= 1'h0;
         wr(a, 8'h00, 8'h80);
         repeat (6) @(posedge sys_clk);
         @(negedge sys_clk);
         chk({7'h0, pwr[c]}, 8'h01);
         wr(a, 8'h00, 8'h80);
         // the rise is detected on the very edge that takes a clear
         raw[c] <= 1'h1;
         @(posedge sys_clk);
         wr(a, 8'h00, 8'h80);
         rd(a, 8'h00, 8'hE0);
         wr(a, 8'h00, 8'h80);
         rd(a, 8'h00, 8'hC0);
         @(posedge sys_clk);
         raw[c] <= 1'h0;
         repeat (6) @(posedge sys_clk);
         rd(a, 8'h00, 8'h90);
         if (c == 0) begin
            wr(8'h9D, 8'h00, 8'h90);
            src_en <= 1'h1;
            repeat (3) @(posedge sys_clk);
            @(negedge sys_clk);
            chk({7'h0, irq}, 8'h00);
            @(posedge sys_clk);
            glb_en <= 1'h1;
            repeat (3) @(posedge sys_clk);
            @(negedge sys_clk);
            chk({7'h0, irq}, 8'h01);
            wr(8'h9D, 8'h00, 8'hA0);
            repeat (3) @(posedge sys_clk);
            @(negedge sys_clk);
            chk({7'h0, irq}, 8'h00);
         end
         // only the channel with edge enables may raise the request
         @(posedge sys_clk);
         raw[c] <= 1'h1;
         repeat (6) @(posedge sys_clk);
         @(negedge sys_clk);
         chk({7'h0, irq}, {7'h0, c == 0});
         wr(a, 8'h00, 8'h80);
         // switch off with the output high: no falling flag may follow
         wr(a, 8'h00, 8'h00);
         repeat (2) @(posedge sys_clk);
         @(negedge sys_clk);
         chk({7'h0, pwr[c]}, 8'h00);
         rd(a, 8'h00, 8'h00);
      end
      give_verdict();
   end
   // hang guard, far beyond the few hundred cycles the tests need
   initial begin
      #400000;
      n_fail++;
      give_verdict();
   end
endmodule // tb_top
